// ### bench/battery_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Battery pack and analog comparator front
// ----------------------------------------
module battery_model #(
  parameter int RCH_STEP_MV = 50
) (
  // Bench controls
  input wire logic [12:0] vbat_mv,
  input wire logic present,
  input wire logic current_low,
  input wire logic power_good,
  // Block outputs seen by the analog side
  input wire logic discharge_en,
  input wire logic [5:0] vreg_code_out,
  input wire logic [1:0] recharge_offset_out,
  // Comparator levels
  output logic [5:0] comparators
);
  logic [12:0] vreg_mv;
  logic [12:0] seen_mv;
  logic [12:0] rch_mv;
  // A missing pack collapses under the check sink, so the check must fail
  always_comb begin
    vreg_mv = 13'hdac + 13'h14 * {7'h00, vreg_code_out};
    rch_mv = 13'(RCH_STEP_MV) * ({11'h000, recharge_offset_out} + 13'h1);
    seen_mv = (!present && discharge_en) ? 13'h0000 : vbat_mv;
    comparators[0] = seen_mv > 13'h834;
    comparators[1] = seen_mv > 13'he74;
    comparators[2] = seen_mv >= vreg_mv;
    comparators[3] = current_low;
    comparators[4] = seen_mv > vreg_mv - rch_mv;
    comparators[5] = power_good;
  end
endmodule

// ### bench/tb_charge_mode_sequencer.sv
`timescale 1ns/1ps
module tb_charge_mode_sequencer;
  logic clk;
  logic arst_n;
  logic cfg_write;
  logic fault_clear;
  logic present;
  logic current_low;
  logic power_good;
  logic [12:0] vbat_mv;
  logic [5:0] comparators;
  logic pwm_charge_en, boost_en, discharge_en, stat_out, stat_oe_n;
  logic [3:0] current_code;
  logic [2:0] term_current_code, boost_volt_out, fault_bits;
  logic [5:0] vreg_code_out;
  logic [1:0] recharge_offset_out, charge_status;
  charge_pkg::mode_type op_mode;
  charge_pkg::phase_type charge_phase;
  charge_pkg::cfg_type cfg;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  // --------------------
  // Block and battery
  // --------------------
  charge_mode_sequencer #(.DISCHARGE_CYCLES(20), .TERM_WINDOW_CYCLES(40),
    .TERM_DEGLITCH_CYCLES(5)) charge_mode_sequencer_i (.clk(clk), .arst_n(arst_n),
    .clk_en(1'b1), .cfg_write(cfg_write), .termination_enable(cfg.termination_enable),
    .charge_disable(cfg.charge_disable), .high_impedance_select(cfg.high_impedance_select),
    .boost_select(cfg.boost_select), .fast_charge_current(cfg.fast_charge_current),
    .termination_current(cfg.termination_current), .vreg_code(cfg.vreg_code),
    .recharge_offset(cfg.recharge_offset), .boost_volt_code(cfg.boost_volt_code),
    .fault_clear(fault_clear), .comparators(comparators), .pwm_charge_en(pwm_charge_en),
    .boost_en(boost_en), .discharge_en(discharge_en), .current_code(current_code),
    .term_current_code(term_current_code), .vreg_code_out(vreg_code_out),
    .recharge_offset_out(recharge_offset_out), .boost_volt_out(boost_volt_out),
    .op_mode(op_mode), .charge_phase(charge_phase), .charge_status(charge_status),
    .fault_bits(fault_bits), .stat_out(stat_out), .stat_oe_n(stat_oe_n));
  battery_model battery_model_i (.vbat_mv(vbat_mv), .present(present),
    .current_low(current_low), .power_good(power_good), .discharge_en(discharge_en),
    .vreg_code_out(vreg_code_out), .recharge_offset_out(recharge_offset_out),
    .comparators(comparators));
  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // --------------------
  // Shared tasks
  // --------------------
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bounded wait on mode (md=1) or phase, then compare
  task wt(input bit md, input logic [2:0] v);
    int n;
    n = 0;
    while ((md ? op_mode : charge_phase) !== v && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk(md ? op_mode : charge_phase, v);
  endtask
  // One-cycle settings write; outputs land one edge later
  task wr();
    @(negedge clk) cfg_write = 1'b1;
    @(negedge clk) cfg_write = 1'b0;
    @(negedge clk);
  endtask
  task rst();
    arst_n = 1'b0;
    repeat (20) @(negedge clk);
    chk(op_mode, charge_pkg::M_LOAD);
    arst_n = 1'b1;
  endtask
  task print_verdict();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // --------------------
  // Scenarios
  // --------------------
  initial begin
    cfg = '{1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 3'h0, 6'h02, 2'h1, 3'h0};
    {cfg_write, fault_clear, current_low, present} = 4'h1;
    power_good = 1'b1;
    vbat_mv = 13'h708; // 1.8 V, below short
    rst();
    wt(1, charge_pkg::M_CHARGE);
    chk({vreg_code_out, recharge_offset_out}, {6'h02, 2'h1});
    chk(boost_volt_out, 3'h0);
    wt(0, charge_pkg::P_PRE);
    chk({pwm_charge_en, current_code, charge_status, stat_oe_n}, 8'h82);
    cfg.fast_charge_current = 4'ha;
    cfg.termination_current = 3'h5;
    cfg.vreg_code = 6'h3f;
    wr();
    chk(term_current_code, 3'h5);
    chk(vreg_code_out, 6'h32);
    vbat_mv = 13'hbb8; // 3.0 V
    wt(0, charge_pkg::P_FAST);
    chk(current_code, 4'ha);
    vbat_mv = 13'h1194; // 4.5 V, at regulation
    wt(0, charge_pkg::P_CV);
    cfg.termination_enable = 1'b0;
    wr();
    current_low = 1'b1;
    repeat (100) @(negedge clk);
    chk({charge_phase, charge_status}, {3'h3, 2'h1});
    cfg.termination_enable = 1'b1;
    wr();
    wt(0, charge_pkg::P_CHECK);
    chk({discharge_en, pwm_charge_en}, 2'h2);
    wt(0, charge_pkg::P_DONE);
    chk({charge_status, stat_oe_n, stat_out}, {2'h2, 1'b1, 1'b0});
    current_low = 1'b0;
    vbat_mv = 13'h10cc; // 4.3 V, below recharge point
    wt(0, charge_pkg::P_FAST);
    vbat_mv = 13'h1194;
    current_low = 1'b1;
    wt(0, charge_pkg::P_CHECK);
    present = 1'b0;
    wt(0, charge_pkg::P_IDLE);
    chk({fault_bits, charge_status, vreg_code_out[2:0]}, {3'h7, 2'h3, 3'h2});
    {current_low, present} = 2'h1;
    cfg.charge_disable = 1'b1;
    wr();
    cfg.charge_disable = 1'b0;
    wr();
    repeat (10) @(negedge clk);
    chk(charge_phase, charge_pkg::P_IDLE);
    @(negedge clk) fault_clear = 1'b1;
    @(negedge clk) fault_clear = 1'b0;
    cfg.charge_disable = 1'b1;
    wr();
    cfg.charge_disable = 1'b0;
    wr();
    wt(0, charge_pkg::P_CV);
    cfg.boost_select = 1'b1;
    wr();
    wt(1, charge_pkg::M_BOOST);
    chk({boost_en, pwm_charge_en}, 2'h2);
    cfg.high_impedance_select = 1'b1;
    wr();
    wt(1, charge_pkg::M_HIZ);
    chk({boost_en, pwm_charge_en}, 2'h0);
    {cfg.high_impedance_select, cfg.boost_select} = 2'h0;
    wr();
    wt(1, charge_pkg::M_CHARGE);
    // A mode change alone is no start event; an input power cycle is
    chk(charge_phase, charge_pkg::P_IDLE);
    power_good = 1'b0;
    repeat (5) @(negedge clk);
    power_good = 1'b1;
    wt(0, charge_pkg::P_CV);
    vbat_mv = 13'hfa0; // 4.0 V, above weak threshold
    rst();
    wt(1, charge_pkg::M_HIZ);
    print_verdict();
  end
endmodule

// ### rtl/charge_defs.svh
`ifndef CHARGE_DEFS_SVH
`define CHARGE_DEFS_SVH

// Clock rate
`define CLK_KHZ 50000
// Timing, in milliseconds, and derived cycle counts
`define DISCHARGE_TIME_MS 262
`define DISCHARGE_CYCLES (`DISCHARGE_TIME_MS * `CLK_KHZ)
`define TERM_WINDOW_MS 64
`define TERM_WINDOW_CYCLES (`TERM_WINDOW_MS * `CLK_KHZ)
`define TERM_DEGLITCH_MS 8
`define TERM_DEGLITCH_CYCLES (`TERM_DEGLITCH_MS * `CLK_KHZ)
// Comparator input bit positions
`define CMP_ABOVE_SHORT 0
`define CMP_ABOVE_WEAK 1
`define CMP_AT_REGULATION 2
`define CMP_BELOW_TERM 3
`define CMP_ABOVE_RECHARGE 4
`define CMP_POWER_GOOD 5
`define CMP_COUNT 6
// Setting reset values
`define TERM_EN_RST 1'b1
`define CHARGE_DIS_RST 1'b0
`define HIZ_SEL_RST 1'b0
`define BOOST_SEL_RST 1'b0
`define FAST_CURRENT_RST 4'h0
`define TERM_CURRENT_RST 3'h0
`define VREG_CODE_RST 6'h02
`define VREG_CODE_MAX 6'h32
`define RECHARGE_OFFSET_RST 2'h1
`define BOOST_VOLT_RST 3'h0
`define PRECHARGE_CODE 4'h0
// Status and fault encodings
`define STATUS_READY 2'h0
`define STATUS_CHARGING 2'h1
`define STATUS_DONE 2'h2
`define STATUS_FAULT 2'h3
`define FAULT_NONE 3'h0
`define FAULT_NO_BATTERY 3'h7
`define SETTLE_CYCLES 2'h3
`endif

// ### rtl/charge_mode_sequencer.sv
`timescale 1ns/1ps
`include "charge_defs.svh"
module charge_mode_sequencer #(
  parameter int DISCHARGE_CYCLES = `DISCHARGE_CYCLES,
  parameter int TERM_WINDOW_CYCLES = `TERM_WINDOW_CYCLES,
  parameter int TERM_DEGLITCH_CYCLES = `TERM_DEGLITCH_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Host settings, taken on cfg_write; fault_clear acts at once
  input wire logic cfg_write,
  input wire logic termination_enable,
  input wire logic charge_disable,
  input wire logic high_impedance_select,
  input wire logic boost_select,
  input wire logic [3:0] fast_charge_current,
  input wire logic [2:0] termination_current,
  input wire logic [5:0] vreg_code,
  input wire logic [1:0] recharge_offset,
  input wire logic [2:0] boost_volt_code,
  input wire logic fault_clear,
  // Analog comparator results, asynchronous
  input wire logic [`CMP_COUNT-1:0] comparators,
  // Converter control
  output logic pwm_charge_en,
  output logic boost_en,
  output logic discharge_en,
  output logic [3:0] current_code,
  output logic [2:0] term_current_code,
  output logic [5:0] vreg_code_out,
  output logic [1:0] recharge_offset_out,
  output logic [2:0] boost_volt_out,
  // Status
  output charge_pkg::mode_type op_mode,
  output charge_pkg::phase_type charge_phase,
  output logic [1:0] charge_status,
  output logic [2:0] fault_bits,
  output logic stat_out,
  output logic stat_oe_n
);
  timer_if win ();
  timer_if chk ();

  // ----------------------------------------
  // Comparator synchronisers
  // ----------------------------------------
  logic [`CMP_COUNT-1:0] cmp_meta_reg;
  logic [`CMP_COUNT-1:0] cmp_reg;
  logic pwr_q_reg;

  // Two flops per comparator; only the second stage feeds the logic
  genvar gi;
  generate
    for (gi = 0; gi < `CMP_COUNT; gi++) begin : g_sync
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          cmp_meta_reg[gi] <= 1'b0;
          cmp_reg[gi] <= 1'b0;
        end else if (clk_en) begin
          cmp_meta_reg[gi] <= comparators[gi];
          cmp_reg[gi] <= cmp_meta_reg[gi];
        end
      end
    end
  endgenerate

  logic above_short;
  logic above_weak;
  logic at_regulation;
  logic below_term;
  logic above_recharge;
  logic power_good;
  assign above_short = cmp_reg[`CMP_ABOVE_SHORT];
  assign above_weak = cmp_reg[`CMP_ABOVE_WEAK];
  assign at_regulation = cmp_reg[`CMP_AT_REGULATION];
  assign below_term = cmp_reg[`CMP_BELOW_TERM];
  assign above_recharge = cmp_reg[`CMP_ABOVE_RECHARGE];
  assign power_good = cmp_reg[`CMP_POWER_GOOD];

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  charge_pkg::cfg_type cfg_reg;
  charge_pkg::cfg_type cfg_next;
  charge_pkg::cfg_type cfg_default;
  charge_pkg::cfg_type cfg_in;
  logic restore_defaults;

  assign cfg_default = '{`TERM_EN_RST, `CHARGE_DIS_RST, `HIZ_SEL_RST, `BOOST_SEL_RST,
                         `FAST_CURRENT_RST, `TERM_CURRENT_RST, `VREG_CODE_RST,
                         `RECHARGE_OFFSET_RST, `BOOST_VOLT_RST};
  // Codes above the top of the range are clamped rather than refused
  assign cfg_in = '{termination_enable, charge_disable, high_impedance_select, boost_select,
                    fast_charge_current, termination_current,
                    (vreg_code > `VREG_CODE_MAX) ? `VREG_CODE_MAX : vreg_code,
                    recharge_offset, boost_volt_code};

  // Battery loss outranks a host write in the same cycle
  always_comb begin
    cfg_next = cfg_reg;
    if (restore_defaults) begin
      cfg_next = cfg_default;
    end else if (cfg_write) begin
      cfg_next = cfg_in;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= '{`TERM_EN_RST, `CHARGE_DIS_RST, `HIZ_SEL_RST, `BOOST_SEL_RST,
                   `FAST_CURRENT_RST, `TERM_CURRENT_RST, `VREG_CODE_RST,
                   `RECHARGE_OFFSET_RST, `BOOST_VOLT_RST};
    end else if (clk_en) begin
      cfg_reg <= cfg_next;
    end
  end

  // ----------------------------------------
  // Operating mode
  // ----------------------------------------
  charge_pkg::mode_type mode_reg;
  charge_pkg::mode_type mode_next;
  charge_pkg::mode_type mode_target;
  charge_pkg::mode_type gap_dest_reg;
  charge_pkg::mode_type gap_dest_next;
  logic [1:0] settle_reg;
  logic [1:0] settle_next;
  logic req_reg;
  logic req_next;

  // High impedance wins over boost when both are selected
  always_comb begin
    if (cfg_reg.high_impedance_select) begin
      mode_target = charge_pkg::M_HIZ;
    end else if (cfg_reg.boost_select) begin
      mode_target = charge_pkg::M_BOOST;
    end else begin
      mode_target = charge_pkg::M_CHARGE;
    end
  end

  // Mode only moves on a host write, so the start-up choice is kept until told otherwise
  always_comb begin
    mode_next = mode_reg;
    gap_dest_next = gap_dest_reg;
    settle_next = settle_reg;
    req_next = req_reg;
    unique case (mode_reg)
      charge_pkg::M_LOAD: begin
        // Wait for the synchroniser to hold a real sample
        if (settle_reg == `SETTLE_CYCLES) begin
          mode_next = above_weak ? charge_pkg::M_HIZ : charge_pkg::M_CHARGE;
        end else begin
          settle_next = settle_reg + 2'h1;
        end
      end
      charge_pkg::M_GAP: begin
        mode_next = gap_dest_reg;
      end
      default: begin
        if (req_reg) begin
          req_next = 1'b0;
          if (mode_target != mode_reg) begin
            gap_dest_next = mode_target;
            mode_next = charge_pkg::M_GAP;
          end
        end
      end
    endcase
    if (cfg_write) begin
      req_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= charge_pkg::M_LOAD;
      gap_dest_reg <= charge_pkg::M_CHARGE;
      settle_reg <= 2'h0;
      req_reg <= 1'b0;
    end else if (clk_en) begin
      mode_reg <= mode_next;
      gap_dest_reg <= gap_dest_next;
      settle_reg <= settle_next;
      req_reg <= req_next;
    end
  end

  // ----------------------------------------
  // Charge phases
  // ----------------------------------------
  charge_pkg::phase_type phase_reg;
  charge_pkg::phase_type phase_next;
  logic start_reg;
  logic start_next;
  logic [2:0] fault_reg;
  logic [2:0] fault_next;
  charge_pkg::count_type dg_reg;
  charge_pkg::count_type dg_next;
  logic allowed;
  logic enable_rise;
  logic pwr_rise;
  logic term_met;

  assign allowed = (mode_reg == charge_pkg::M_CHARGE) && !cfg_reg.charge_disable && power_good;
  assign enable_rise = cfg_write && !charge_disable && cfg_reg.charge_disable;
  assign pwr_rise = power_good && !pwr_q_reg;
  // Strictly longer than the deglitch time, inside a running window
  assign term_met = (dg_reg > charge_pkg::count_type'(TERM_DEGLITCH_CYCLES));

  always_comb begin
    phase_next = phase_reg;
    start_next = start_reg;
    fault_next = fault_reg;
    dg_next = 32'h0;
    win.start = 1'b0;
    chk.start = 1'b0;
    restore_defaults = 1'b0;
    if (fault_clear) begin
      fault_next = `FAULT_NONE;
    end
    unique case (phase_reg)
      charge_pkg::P_IDLE: begin
        if (allowed && start_reg && fault_reg == `FAULT_NONE) begin
          start_next = 1'b0;
          phase_next = above_short ? charge_pkg::P_FAST : charge_pkg::P_PRE;
        end
      end
      charge_pkg::P_PRE: begin
        if (above_short) begin
          phase_next = charge_pkg::P_FAST;
        end
      end
      charge_pkg::P_FAST: begin
        if (!above_short) begin
          phase_next = charge_pkg::P_PRE;
        end else if (at_regulation) begin
          phase_next = charge_pkg::P_CV;
        end
      end
      charge_pkg::P_CV: begin
        // Low current is ignored entirely while termination is off
        if (cfg_reg.termination_enable && below_term) begin
          win.start = !win.busy;
          dg_next = win.busy ? dg_reg + 32'h1 : 32'h0;
          if (term_met) begin
            phase_next = charge_pkg::P_CHECK;
            chk.start = 1'b1;
            dg_next = 32'h0;
          end
        end
      end
      charge_pkg::P_CHECK: begin
        if (chk.done) begin
          if (above_recharge) begin
            phase_next = charge_pkg::P_DONE;
          end else begin
            phase_next = charge_pkg::P_IDLE;
            fault_next = `FAULT_NO_BATTERY;
            restore_defaults = 1'b1;
          end
        end
      end
      charge_pkg::P_DONE: begin
        if (!above_recharge) begin
          phase_next = above_short ? charge_pkg::P_FAST : charge_pkg::P_PRE;
        end
      end
      default: begin
        phase_next = charge_pkg::P_IDLE;
      end
    endcase
    // Leaving charge mode or losing input parks the sequencer
    if (!allowed && phase_reg != charge_pkg::P_IDLE) begin
      phase_next = charge_pkg::P_IDLE;
      dg_next = 32'h0;
    end
    // A start event in the same cycle as a start is never lost
    if (pwr_rise || enable_rise) begin
      start_next = 1'b1;
    end
  end

  assign win.length = charge_pkg::count_type'(TERM_WINDOW_CYCLES);
  assign chk.length = charge_pkg::count_type'(DISCHARGE_CYCLES);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= charge_pkg::P_IDLE;
      start_reg <= 1'b1;
      fault_reg <= `FAULT_NONE;
      dg_reg <= 32'h0;
      pwr_q_reg <= 1'b0;
    end else if (clk_en) begin
      phase_reg <= phase_next;
      start_reg <= start_next;
      fault_reg <= fault_next;
      dg_reg <= dg_next;
      pwr_q_reg <= power_good;
    end
  end

  interval_timer u_window (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .tmr(win));
  interval_timer u_check (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .tmr(chk));

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  logic pwm_next;
  logic boost_next;
  logic dis_next;
  logic [3:0] cur_next;
  logic [1:0] status_next;

  // Decoded from next state so outputs line up with the phase they belong to
  always_comb begin
    pwm_next = (mode_next == charge_pkg::M_CHARGE) &&
               (phase_next inside {charge_pkg::P_PRE, charge_pkg::P_FAST, charge_pkg::P_CV});
    boost_next = (mode_next == charge_pkg::M_BOOST);
    dis_next = (phase_next == charge_pkg::P_CHECK);
    cur_next = (phase_next == charge_pkg::P_PRE) ? `PRECHARGE_CODE
                                                  : cfg_next.fast_charge_current;
    if (fault_next != `FAULT_NONE) begin
      status_next = `STATUS_FAULT;
    end else if (phase_next == charge_pkg::P_DONE) begin
      status_next = `STATUS_DONE;
    end else if (phase_next == charge_pkg::P_IDLE) begin
      status_next = `STATUS_READY;
    end else begin
      status_next = `STATUS_CHARGING;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_charge_en <= 1'b0;
      boost_en <= 1'b0;
      discharge_en <= 1'b0;
      current_code <= `PRECHARGE_CODE;
      charge_status <= `STATUS_READY;
    end else if (clk_en) begin
      pwm_charge_en <= pwm_next;
      boost_en <= boost_next;
      discharge_en <= dis_next;
      current_code <= cur_next;
      charge_status <= status_next;
    end
  end

  assign term_current_code = cfg_reg.termination_current;
  assign vreg_code_out = cfg_reg.vreg_code;
  assign recharge_offset_out = cfg_reg.recharge_offset;
  assign boost_volt_out = cfg_reg.boost_volt_code;
  assign op_mode = mode_reg;
  assign charge_phase = phase_reg;
  assign fault_bits = fault_reg;
  // Open-drain status pin pulls low only while charging
  assign stat_out = 1'b0;
  assign stat_oe_n = (charge_status != `STATUS_CHARGING);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_check_ends;
    clk_en && phase_reg == charge_pkg::P_CHECK && chk.done;
  endsequence
  sequence s_cv_exit;
    clk_en && allowed && phase_reg == charge_pkg::P_CV && cfg_reg.termination_enable &&
    below_term && term_met;
  endsequence

  a_pre_to_fast: assert property (clk_en && allowed && phase_reg == charge_pkg::P_PRE &&
    above_short |=> phase_reg == charge_pkg::P_FAST) else $error("pre-charge did not advance");
  a_fast_current: assert property (clk_en && pwm_next && phase_next == charge_pkg::P_FAST
    |=> current_code == cfg_reg.fast_charge_current) else $error("bad fast current");
  a_cv_entry: assert property (clk_en && allowed && phase_reg == charge_pkg::P_FAST &&
    above_short && at_regulation |=> phase_reg == charge_pkg::P_CV) else $error("no CV entry");
  a_vreg_range: assert property (cfg_reg.vreg_code <= `VREG_CODE_MAX)
    else $error("regulation code out of range");
  a_no_term_off: assert property (clk_en && phase_reg == charge_pkg::P_CV &&
    !cfg_reg.termination_enable |=> phase_reg != charge_pkg::P_CHECK)
    else $error("terminated while disabled");
  a_term_check: assert property (s_cv_exit |=> phase_reg == charge_pkg::P_CHECK && chk.busy
    ##0 discharge_en && !pwm_charge_en) else $error("check not entered");
  a_done_present: assert property (s_check_ends ##0 above_recharge && allowed
    |=> phase_reg == charge_pkg::P_DONE ##0 charge_status == `STATUS_DONE)
    else $error("done not declared");
  a_absent_fault: assert property (s_check_ends ##0 !above_recharge
    |=> fault_bits == `FAULT_NO_BATTERY && cfg_reg == cfg_default)
    else $error("absent battery not handled");
  a_recharge: assert property (clk_en && allowed && phase_reg == charge_pkg::P_DONE &&
    !above_recharge |=> phase_reg inside {charge_pkg::P_PRE, charge_pkg::P_FAST})
    else $error("no recharge");
  a_fault_blocks: assert property (clk_en && phase_reg == charge_pkg::P_IDLE &&
    fault_reg != `FAULT_NONE |=> phase_reg == charge_pkg::P_IDLE)
    else $error("started with fault");
  a_mode_gap: assert property (clk_en && mode_reg == charge_pkg::M_GAP
    |-> !pwm_charge_en && !boost_en) else $error("converters overlap");
  a_hiz_quiet: assert property (mode_reg == charge_pkg::M_HIZ && $past(mode_reg) ==
    charge_pkg::M_HIZ |-> !pwm_charge_en && !boost_en) else $error("active in hiz");
  a_startup: assert property (clk_en && mode_reg == charge_pkg::M_LOAD &&
    settle_reg == `SETTLE_CYCLES |=> mode_reg == (above_weak ? charge_pkg::M_HIZ :
    charge_pkg::M_CHARGE) || $past(above_weak) != above_weak) else $error("bad start mode");
endmodule

// ### rtl/charge_pkg.sv
package charge_pkg;
  typedef logic [31:0] count_type;
  typedef enum logic [2:0] {
    M_LOAD = 3'b000, M_CHARGE = 3'b001, M_BOOST = 3'b010, M_HIZ = 3'b011, M_GAP = 3'b100
  } mode_type;
  typedef enum logic [2:0] {
    P_IDLE = 3'b000, P_PRE = 3'b001, P_FAST = 3'b010, P_CV = 3'b011,
    P_CHECK = 3'b100, P_DONE = 3'b101
  } phase_type;
  typedef struct packed {
    logic termination_enable;
    logic charge_disable;
    logic high_impedance_select;
    logic boost_select;
    logic [3:0] fast_charge_current;
    logic [2:0] termination_current;
    logic [5:0] vreg_code;
    logic [1:0] recharge_offset;
    logic [2:0] boost_volt_code;
  } cfg_type;
endpackage

// ### rtl/interval_timer.sv
`timescale 1ns/1ps
module interval_timer (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Timer control
  timer_if.timer tmr
);
  charge_pkg::count_type count_reg;
  charge_pkg::count_type count_next;
  logic done_reg;
  logic done_next;

  // ----------------------------------------
  // Countdown
  // ----------------------------------------
  // A start while running reloads, so the owner can restart the interval
  always_comb begin
    count_next = count_reg;
    done_next = 1'b0;
    if (tmr.start) begin
      count_next = tmr.length;
    end else if (count_reg != 32'h0) begin
      count_next = count_reg - 32'h1;
      done_next = (count_reg == 32'h1);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= 32'h0;
      done_reg <= 1'b0;
    end else if (clk_en) begin
      count_reg <= count_next;
      done_reg <= done_next;
    end
  end

  assign tmr.busy = (count_reg != 32'h0);
  assign tmr.done = done_reg;
endmodule

// ### rtl/timer_if.sv
`timescale 1ns/1ps
interface timer_if;
  logic start;
  charge_pkg::count_type length;
  logic busy;
  logic done;
  modport owner (output start, output length, input busy, input done);
  modport timer (input start, input length, output busy, output done);
endinterface
